// ===== hw/eepsl_top.sv
`timescale 1ns/100ps
// How it works
// - Storage is bytes; 256, 512, 1024 or 2048 locations by density.
// - Page writes take up to 8 bytes (2K) or 16 bytes otherwise.
// - A short page write updates only the bytes actually received.
// - Programming finishes on its own within five milliseconds after stop.
// - 2K density compares all three select pins.
// - 4K density compares only the two upper select pins.
// - 8K density compares only the top select pin.
// - 16K density ignores all select pins.
// - Data line is only pulled low or released, never driven high.
// - Input sampled on clock rise; output changes after clock fall.
// - Write protect low allows normal reads and writes.
// - Write protect high blocks all array writes.
// - Address byte: fixed nibble, three select/page bits, read/write bit.
// - Outside programming, each received word except an unmatched address byte is acknowledged low on the ninth clock.
// - Data fall with clock high is start; data rise is stop.
// - Page writes wrap the low offset bits within the same page.
module eepsl_top import eepsl_pkg::*; #(
	parameter int DENSITY = EEPSL_DENS_2K,
	parameter int TWR_CYCLES = EEPSL_TWR_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic write_protect,
	input wire logic select_pin_low,
	input wire logic select_pin_mid,
	input wire logic select_pin_high,
	output logic prog_busy
);
	localparam int AW = 8 + DENSITY;
	localparam int DEPTH = 1 << AW;
	localparam int PW = (DENSITY == EEPSL_DENS_2K) ? 3 : 4;
	localparam int PAGE = 1 << PW;
	localparam logic [AW-1:0] LOW_MASK = AW'(8'h ff); // Word address byte within the full address
	localparam int CW = $clog2(TWR_CYCLES + 1);

	// ==========================================
	// Pin synchronisers
	eepsl_pins_t meta_reg, sync_reg, prev_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= '1;
			sync_reg <= '1;
			prev_reg <= '1;
		end else begin
			meta_reg <= '{scl: scl_in, sda: sda_in, wp: write_protect};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end
	logic scl_rise, scl_fall, start_cond, stop_cond;
	assign scl_rise = sync_reg.scl & ~prev_reg.scl;
	assign scl_fall = ~sync_reg.scl & prev_reg.scl;
	assign start_cond = sync_reg.scl & prev_reg.scl & prev_reg.sda & ~sync_reg.sda;
	assign stop_cond = sync_reg.scl & prev_reg.scl & ~prev_reg.sda & sync_reg.sda;

	// ==========================================
	// Storage and page buffer
	logic [7:0] mem_reg [DEPTH];
	logic [7:0] page_data_reg [PAGE];
	logic [PAGE-1:0] page_valid_reg;
	logic [AW-1:0] addr_reg;
	logic [AW-1:0] wbase_reg;

	// ==========================================
	// Bit-level state
	eepsl_phase_t phase_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic ack_slot_reg;
	logic rd_mode_reg;
	logic wr_pending_reg;
	logic [CW-1:0] twr_cnt_reg;

	// Select strap synchroniser
	logic [2:0] sel_meta_reg, sel_sync_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_meta_reg <= '0;
			sel_sync_reg <= '0;
		end else begin
			sel_meta_reg <= {select_pin_high, select_pin_mid, select_pin_low};
			sel_sync_reg <= sel_meta_reg;
		end
	end

	// Address match per density
	logic dev_match;
	always_comb begin
		dev_match = (shift_reg[7:4] == EEPSL_FIXED_PATTERN);
		case (DENSITY)
			EEPSL_DENS_2K: dev_match = dev_match && shift_reg[3:1] == sel_sync_reg;
			EEPSL_DENS_4K: dev_match = dev_match && shift_reg[3:2] == sel_sync_reg[2:1];
			EEPSL_DENS_8K: dev_match = dev_match && shift_reg[3] == sel_sync_reg[2];
			default: dev_match = dev_match;
		endcase
	end

	// Current byte received (complete on eighth rise)
	logic [7:0] rx_byte;
	assign rx_byte = shift_reg;

	// ==========================================
	// Protocol engine
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_reg <= EEPSL_IDLE;
			bit_cnt_reg <= '0;
			shift_reg <= '0;
			ack_slot_reg <= 1'b0;
			rd_mode_reg <= 1'b0;
			addr_reg <= '0;
			wbase_reg <= '0;
			page_valid_reg <= '0;
		end else if (prog_busy) begin
			phase_reg <= EEPSL_IDLE;
			ack_slot_reg <= 1'b0;
		end else if (stop_cond) begin
			phase_reg <= EEPSL_IDLE;
			ack_slot_reg <= 1'b0;
		end else if (start_cond) begin
			phase_reg <= EEPSL_DEVADDR;
			bit_cnt_reg <= '0;
			ack_slot_reg <= 1'b0;
			page_valid_reg <= '0;
		end else if (scl_rise && phase_reg != EEPSL_IDLE && phase_reg != EEPSL_IGNORE) begin
			if (bit_cnt_reg == EEPSL_ACK_BIT) begin
				bit_cnt_reg <= '0;
				// Master nack ends a read
				if (phase_reg == EEPSL_RDATA && sync_reg.sda)
					phase_reg <= EEPSL_IGNORE;
			end else begin
				shift_reg <= {shift_reg[6:0], sync_reg.sda};
				bit_cnt_reg <= bit_cnt_reg + 4'h 1;
			end
		end else if (scl_fall && phase_reg != EEPSL_IDLE && phase_reg != EEPSL_IGNORE) begin
			if (bit_cnt_reg == EEPSL_ACK_BIT && !ack_slot_reg && phase_reg != EEPSL_RDATA) begin
				// End of eighth bit: decode the byte
				case (phase_reg)
					EEPSL_DEVADDR: begin
						if (dev_match) begin
							ack_slot_reg <= 1'b1;
							rd_mode_reg <= rx_byte[EEPSL_RW_BIT];
							// Page bits land above the word byte; the cast drops unused ones
							addr_reg <= (addr_reg & LOW_MASK) | AW'({rx_byte[3:1], 8'h 00});
						end else begin
							phase_reg <= EEPSL_IGNORE;
						end
					end
					EEPSL_WORDADDR: begin
						ack_slot_reg <= 1'b1;
						addr_reg[7:0] <= rx_byte;
						wbase_reg <= (addr_reg & ~LOW_MASK) | AW'(rx_byte);
					end
					EEPSL_WDATA: begin
						ack_slot_reg <= 1'b1;
						page_data_reg[addr_reg[PW-1:0]] <= rx_byte;
						page_valid_reg[addr_reg[PW-1:0]] <= 1'b1;
						addr_reg[PW-1:0] <= addr_reg[PW-1:0] + 1'b1;
					end
					default: phase_reg <= EEPSL_IGNORE;
				endcase
			end else if (bit_cnt_reg == '0 && ack_slot_reg) begin
				// End of ninth clock: release and move on
				ack_slot_reg <= 1'b0;
				case (phase_reg)
					EEPSL_DEVADDR: phase_reg <= rd_mode_reg ? EEPSL_RDATA : EEPSL_WORDADDR;
					EEPSL_WORDADDR: phase_reg <= EEPSL_WDATA;
					default: phase_reg <= phase_reg;
				endcase
			end else if (bit_cnt_reg == EEPSL_ACK_BIT && phase_reg == EEPSL_RDATA) begin
				addr_reg <= addr_reg + 1'b1;
			end
		end
	end

	// ==========================================
	// Read shifter and data line driver
	logic [7:0] tx_reg;
	logic drive_low_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_reg <= '0;
			drive_low_reg <= 1'b0;
		end else if (prog_busy || start_cond || stop_cond) begin
			drive_low_reg <= 1'b0;
		end else if (scl_fall) begin
			// Read byte loads as the address ack or the controller's ack ends
			if (bit_cnt_reg == '0 && ((phase_reg == EEPSL_DEVADDR && ack_slot_reg && rd_mode_reg) ||
				(phase_reg == EEPSL_RDATA && !ack_slot_reg))) begin
				tx_reg <= {mem_reg[addr_reg][6:0], 1'b0};
				drive_low_reg <= ~mem_reg[addr_reg][7];
			end else if (phase_reg == EEPSL_RDATA && bit_cnt_reg < EEPSL_ACK_BIT && bit_cnt_reg != '0) begin
				tx_reg <= {tx_reg[6:0], 1'b0};
				drive_low_reg <= ~tx_reg[7];
			end else if (bit_cnt_reg == EEPSL_ACK_BIT && !ack_slot_reg && (phase_reg == EEPSL_DEVADDR ||
				phase_reg == EEPSL_WORDADDR || phase_reg == EEPSL_WDATA)) begin
				drive_low_reg <= (phase_reg != EEPSL_DEVADDR) || dev_match;
			end else begin
				drive_low_reg <= 1'b0;
			end
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe_n = ~drive_low_reg;

	// ==========================================
	// Programming interval and array commit
	// One-cycle commit request at a stop that ends a data phase
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pending_reg <= 1'b0;
		end else begin
			wr_pending_reg <= stop_cond && !prog_busy && (phase_reg == EEPSL_WDATA) && (|page_valid_reg);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			twr_cnt_reg <= '0;
		end else if (wr_pending_reg) begin
			twr_cnt_reg <= CW'(TWR_CYCLES);
		end else if (twr_cnt_reg != '0) begin
			twr_cnt_reg <= twr_cnt_reg - 1'b1;
		end
	end
	assign prog_busy = (twr_cnt_reg != '0);

	always_ff @(posedge core_clk) begin
		if (wr_pending_reg && !sync_reg.wp) begin
			for (int i = 0; i < PAGE; i++) begin
				if (page_valid_reg[i])
					mem_reg[{wbase_reg[AW-1:PW], PW'(i)}] <= page_data_reg[i];
			end
		end
	end
endmodule

// ===== hw/eepsl_pkg.sv
package eepsl_pkg;
	// ==========================================
	// Address byte layout
	localparam logic [3:0] EEPSL_FIXED_PATTERN = 4'h a;
	localparam int EEPSL_RW_BIT = 0;
	localparam int EEPSL_BITS_PER_WORD = 8;
	localparam logic [3:0] EEPSL_ACK_BIT = 4'h 8;
	// ==========================================
	// Density codes
	localparam int EEPSL_DENS_2K = 0;
	localparam int EEPSL_DENS_4K = 1;
	localparam int EEPSL_DENS_8K = 2;
	localparam int EEPSL_DENS_16K = 3;
	// ==========================================
	// Programming interval
	localparam int EEPSL_CLK_HZ = 50_000_000;
	localparam int EEPSL_TWR_US = 5000;
	localparam int EEPSL_TWR_CYCLES = (EEPSL_CLK_HZ / 1_000_000) * EEPSL_TWR_US;
	// ==========================================
	// Bus phases
	typedef enum logic [2:0] {
		EEPSL_IDLE,
		EEPSL_DEVADDR,
		EEPSL_WORDADDR,
		EEPSL_WDATA,
		EEPSL_RDATA,
		EEPSL_IGNORE
	} eepsl_phase_t;
	// Pins after synchronising
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
	} eepsl_pins_t;
endpackage

// ===== bench/eepsl_properties.sv
`timescale 1ns/100ps
// ==========================================
// Port checks
module eepsl_checker import eepsl_pkg::*; #(
	parameter int TWR_CYCLES = 50
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic prog_busy
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	int cnt;
	// Busy length counter
	always_ff @(posedge core_clk or posedge sys_rst) cnt <= sys_rst ? 0 : (prog_busy ? cnt + 1 : 0);
	a_out_low: assert property (sda_out == 1'b0) else $error("data driven high");
	a_oe_edge: assert property ($changed(sda_oe_n) |-> !scl_in) else $error("output moved, clock high");
	a_pull_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6]) else $error("pull too short");
	a_busy_mute: assert property (prog_busy |-> sda_oe_n) else $error("pull while busy");
	a_busy_stop: assert property ($rose(prog_busy) |-> scl_in && sda_in) else $error("busy not after stop");
	a_busy_short: assert property ($fell(prog_busy) |-> cnt >= TWR_CYCLES - 2) else $error("busy short");
	a_busy_long: assert property (cnt <= TWR_CYCLES + 1) else $error("busy long");
	a_start_free: assert property ($fell(sda_in) && scl_in |-> sda_oe_n) else $error("pull at start");
endmodule
bind eepsl_top eepsl_checker #(.TWR_CYCLES(TWR_CYCLES)) i_eepsl_checker(.core_clk(core_clk), .sys_rst(sys_rst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .prog_busy(prog_busy));

// ===== bench/eepsl_ctl_model.sv
`timescale 1ns/100ps
// ==========================================
// Bus controller model
module eepsl_ctl_model (
	input wire logic core_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	// Clock idles high outside frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic hold;
		repeat (4) @(posedge core_clk);
	endtask
	// One bit; data moves only with clock low
	task automatic bit_io(input logic b, output logic r);
		@(posedge core_clk);
		sda_drv <= b;
		// Four cycles low, four high: 160 ns per bit
		repeat (3) @(posedge core_clk);
		scl <= 1'b1;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk) r = sda_line;
		repeat (2) @(posedge core_clk);
		scl <= 1'b0;
	endtask
	task automatic start;
		sda_drv <= 1'b1;
		hold;
		scl <= 1'b1;
		hold;
		sda_drv <= 1'b0;
		hold;
		scl <= 1'b0;
	endtask
	task automatic stop;
		@(posedge core_clk);
		sda_drv <= 1'b0;
		hold;
		scl <= 1'b1;
		hold;
		sda_drv <= 1'b1;
		hold;
	endtask
	// Byte out, MSB first, then ack bit
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// ===== bench/eepsl_top_bench.sv
`timescale 1ns/100ps
// ==========================================
// Bench
module eepsl_top_bench;
	import eepsl_pkg::*;
	localparam int TWR = 300;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wp = 1'b0;
	logic [2:0] sel = 3'h5;
	logic scl, sda_drv, sda_out, sda_oe_n, prog_busy, ack;
	logic [7:0] d;
	wire sda_line = sda_drv & (sda_oe_n | sda_out);
	int n_mismatch = 0;
	int n_tests = 0;
	initial forever #10 core_clk = ~core_clk;
	eepsl_top #(.DENSITY(EEPSL_DENS_2K), .TWR_CYCLES(TWR)) i_eepsl_top(.core_clk(core_clk), .sys_rst(sys_rst),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect(wp),
		.select_pin_low(sel[0]), .select_pin_mid(sel[1]), .select_pin_high(sel[2]), .prog_busy(prog_busy));
	eepsl_ctl_model i_eepsl_ctl_model(.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Address byte with read flag
	task automatic dev(input logic [2:0] s, input logic rd, input logic exp);
		i_eepsl_ctl_model.start();
		i_eepsl_ctl_model.wbyte({EEPSL_FIXED_PATTERN, s, rd}, ack);
		chk({7'h00, ack}, {7'h00, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d0, input int n);
		dev(sel, 1'b0, 1'b1);
		i_eepsl_ctl_model.wbyte(a, ack);
		chk({7'h00, ack}, 8'h01);
		for (int i = 0; i < n; i++) i_eepsl_ctl_model.wbyte(d0 + 8'(i), ack);
		chk({7'h00, ack}, 8'h01);
		i_eepsl_ctl_model.stop();
	endtask
	task automatic wait_done;
		int k;
		// Stop reaches the counter through the synchroniser
		repeat (2) @(posedge core_clk);
		chk({7'h00, prog_busy}, 8'h01);
		for (k = 0; k < TWR + 10 && prog_busy !== 1'b0; k++) @(posedge core_clk);
		if (k == TWR + 10) begin
			n_mismatch++;
			close_out();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		dev(sel, 1'b0, 1'b1);
		i_eepsl_ctl_model.wbyte(a, ack);
		dev(sel, 1'b1, 1'b1);
		i_eepsl_ctl_model.rbyte(1'b1, d);
		i_eepsl_ctl_model.stop();
		chk(d, exp);
	endtask
	task automatic s_page;
		wr(8'h06, 8'h3c, 3);
		wait_done();
		wr(8'h10, 8'h40, 9);
		wait_done();
		rd(8'h06, 8'h3c);
		rd(8'h00, 8'h3e);
		rd(8'h10, 8'h48);
		rd(8'h17, 8'h47);
	endtask
	task automatic s_select;
		for (int j = 0; j < 3; j++) begin
			dev(sel ^ 3'(1 << j), 1'b0, 1'b0);
			i_eepsl_ctl_model.stop();
		end
	endtask
	task automatic s_busy;
		wr(8'h20, 8'h77, 1);
		dev(sel, 1'b0, 1'b0);
		i_eepsl_ctl_model.stop();
		wait_done();
		rd(8'h20, 8'h77);
	endtask
	task automatic s_protect;
		@(posedge core_clk) wp <= 1'b1;
		wr(8'h06, 8'h99, 1);
		wait_done();
		rd(8'h06, 8'h3c);
		@(posedge core_clk) wp <= 1'b0;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		s_page();
		s_select();
		s_busy();
		s_protect();
		close_out();
	end
endmodule
